/* design/vhs_sequencer.sv */
// What this block does
// RULE1 - Caller powers modem, transmit DTMF no tone, receive call progress.
// RULE2 - Caller goes off hook, dials, then receives in answer-tone detect.
// RULE3 - After 2100Hz ends, 2225Hz held 155ms starts a 456ms timer.
// RULE4 - Modem's 2225Hz detector also flags unscrambled high-band ones.
// RULE5 - At 456ms, if still present, low-band scrambled ones, high-band rx.
// RULE6 - Scrambled ones for 270ms: rx USART on, 765ms timer, load byte.
// RULE7 - At caller 765ms select data transmission; modem sends the byte.
// RULE8 - Answerer waits for ring, off hook, 2150ms timer, power, low rx.
// RULE9 - At 2150ms send 2100Hz answer tone, start 3300ms timer.
// RULE10 - At 3300ms return to no tone, start 75ms silence timer.
// RULE11 - At 75ms send high-band unscrambled ones, watch for scrambled ones.
// RULE12 - Scrambled ones 270ms: high-band scrambled, 765ms, USART, load byte.
// RULE13 - At answerer 765ms select data transmission; link established.
// RULE14 - Missing detection at a timer end: no tone, on hook, fail.
module vhs_sequencer #(
  parameter int unsigned MS_CYC = vhs_pkg::MS_CYCLES
) (
  input  wire logic                    clk_sys_i,
  input  wire logic                    resetn_i,
  input  wire logic                    call_start_i,
  input  wire logic                    answer_en_i,
  input  wire logic                    abort_i,
  input  wire logic                    dial_done_i,
  input  wire logic                    tx_sync_sel_i,
  input  wire logic [7:0]              first_byte_i,
  input  wire vhs_pkg::vhs_det_t       det_i,
  output vhs_pkg::vhs_modem_ctl_t      ctl_o,
  output logic                         dial_en_o,
  output logic                         tx_load_o,
  output logic [7:0]                   tx_data_o,
  output logic                         connected_o,
  output logic                         fail_o,
  output logic                         busy_o
);

  // ==========================================================
  // States
  // ==========================================================
  typedef enum logic [12:0] {
    ST_IDLE    = 13'h0001,
    ST_DIAL    = 13'h0002,
    ST_WT2100  = 13'h0004,
    ST_END2100 = 13'h0008,
    ST_HI155   = 13'h0010,
    ST_G456    = 13'h0020,
    ST_SCR270  = 13'h0040,
    ST_PRE765  = 13'h0080,
    ST_RING    = 13'h0100,
    ST_T2150   = 13'h0200,
    ST_T3300   = 13'h0400,
    ST_T75     = 13'h0800,
    ST_UNSCR   = 13'h1000
  } vhs_state_t;

  vhs_state_t state_q;
  vhs_state_t state_d;

  // ==========================================================
  // Millisecond tick and timer
  // ==========================================================
  logic [17:0] pre_q;
  logic        tick_q;
  logic [11:0] ms_q;
  logic        tmr_load;
  logic [11:0] tmr_val;

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pre_q  <= 18'h0_0000;
      tick_q <= 1'b0;
    end else if (tmr_load || pre_q == 18'(MS_CYC - 1)) begin
      pre_q  <= 18'h0_0000;
      tick_q <= !tmr_load;
    end else begin
      pre_q  <= pre_q + 18'h0_0001;
      tick_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ms_q <= 12'h000;
    end else if (tmr_load) begin
      ms_q <= tmr_val;
    end else if (tick_q && ms_q != 12'h000) begin
      ms_q <= ms_q - 12'h001;
    end
  end

  // Expiry is seen on the tick that brings the count to zero
  wire expired = tick_q && ms_q == 12'h001;

  // ==========================================================
  // Sequencer
  // ==========================================================
  logic start_call;
  logic caller_q;

  assign start_call = call_start_i && !answer_en_i;

  always_comb begin
    state_d  = state_q;
    tmr_load = 1'b0;
    tmr_val  = 12'h000;
    case (state_q)
      ST_IDLE: begin
        if (start_call) begin
          state_d = ST_DIAL;                              // [RULE1]
        end else if (answer_en_i) begin
          state_d = ST_RING;                              // [RULE8]
        end
      end
      ST_DIAL: begin
        if (dial_done_i) begin
          state_d = ST_WT2100;                            // [RULE2]
        end
      end
      ST_WT2100: begin
        if (det_i.ans_2100) begin
          state_d = ST_END2100;                           // [RULE3]
        end
      end
      ST_END2100: begin
        if (!det_i.ans_2100) begin
          state_d  = ST_HI155;
          tmr_load = 1'b1;
          tmr_val  = 12'(vhs_pkg::T_ANS_HI_MS);
        end
      end
      ST_HI155: begin
        // Qualification restarts whenever the tone drops out
        if (!det_i.ans_2225) begin
          tmr_load = 1'b1;                                // [RULE3]
          tmr_val  = 12'(vhs_pkg::T_ANS_HI_MS);
        end else if (expired) begin
          state_d  = ST_G456;
          tmr_load = 1'b1;
          tmr_val  = 12'(vhs_pkg::T_GUARD_MS);
        end
      end
      ST_G456: begin
        if (expired && det_i.ans_2225) begin
          state_d  = ST_SCR270;                           // [RULE5]
          tmr_load = 1'b1;
          tmr_val  = 12'(vhs_pkg::T_SCR_MS);
        end else if (expired) begin
          state_d = ST_IDLE;                              // [RULE14]
        end
      end
      ST_SCR270, ST_UNSCR: begin
        // Only continuous scrambled ones count
        if (!det_i.scr_ones) begin
          tmr_load = 1'b1;
          tmr_val  = 12'(vhs_pkg::T_SCR_MS);
        end else if (expired) begin
          state_d  = ST_PRE765;                           // [RULE6] [RULE12]
          tmr_load = 1'b1;
          tmr_val  = 12'(vhs_pkg::T_PRELOAD_MS);
        end
      end
      ST_PRE765: begin
        if (expired) begin
          state_d = ST_IDLE;                              // [RULE7] [RULE13]
        end
      end
      ST_RING: begin
        if (!answer_en_i) begin
          state_d = ST_IDLE;
        end else if (det_i.ring) begin
          state_d  = ST_T2150;                            // [RULE8]
          tmr_load = 1'b1;
          tmr_val  = 12'(vhs_pkg::T_RING_MS);
        end
      end
      ST_T2150: begin
        if (expired) begin
          state_d  = ST_T3300;                            // [RULE9]
          tmr_load = 1'b1;
          tmr_val  = 12'(vhs_pkg::T_TONE_MS);
        end
      end
      ST_T3300: begin
        if (expired) begin
          state_d  = ST_T75;                              // [RULE10]
          tmr_load = 1'b1;
          tmr_val  = 12'(vhs_pkg::T_SIL_MS);
        end
      end
      ST_T75: begin
        if (expired) begin
          state_d  = ST_UNSCR;                            // [RULE11]
          tmr_load = 1'b1;
          tmr_val  = 12'(vhs_pkg::T_SCR_MS);
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
    // Abort is a level: holding it keeps the block idle and unarmed
    if (abort_i) begin
      state_d = ST_IDLE;
    end
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      caller_q <= 1'b0;
    end else if (state_q == ST_IDLE) begin
      caller_q <= start_call;
    end
  end

  // ==========================================================
  // Modem control outputs, registered from the next state
  // ==========================================================
  vhs_pkg::vhs_modem_ctl_t ctl_d;

  always_comb begin
    ctl_d = ctl_o;
    case (state_d)
      ST_IDLE: begin
        // Data mode survives completion and holds until abort, or until entry to ST_DIAL or ST_RING resets it
        if (abort_i ||
            (state_q != ST_IDLE && !(state_q == ST_PRE765 && expired))) begin
          ctl_d = vhs_pkg::CTL_RESET;                     // [RULE14]
        end
      end
      ST_DIAL: begin
        ctl_d          = vhs_pkg::CTL_RESET;
        ctl_d.power_up = 1'b1;                            // [RULE1]
        ctl_d.off_hook = 1'b1;                            // [RULE2]
        ctl_d.tx_mode  = vhs_pkg::VHS_TX_DTMF;
        ctl_d.rx_mode  = vhs_pkg::VHS_RX_CALL_PROG;
      end
      ST_WT2100: begin
        ctl_d.tx_mode = vhs_pkg::VHS_TX_NO_TONE;
        ctl_d.rx_mode = vhs_pkg::VHS_RX_ANS_DET;          // [RULE2]
      end
      ST_SCR270: begin
        if (caller_q) begin
          ctl_d.tx_mode     = vhs_pkg::VHS_TX_LO_SCR1;    // [RULE5]
          ctl_d.rx_mode     = vhs_pkg::VHS_RX_V22_HI;
          ctl_d.descram_en  = 1'b1;
          ctl_d.rx_usart_en = 1'b0;
        end
      end
      ST_PRE765: begin
        ctl_d.rx_usart_en = 1'b1;                         // [RULE6] [RULE12]
        if (!caller_q) begin
          ctl_d.tx_mode = vhs_pkg::VHS_TX_HI_SCR1;        // [RULE12]
        end
      end
      ST_RING: begin
        ctl_d = vhs_pkg::CTL_RESET;                       // [RULE8]
      end
      ST_T2150: begin
        ctl_d.off_hook    = 1'b1;                         // [RULE8]
        ctl_d.power_up    = 1'b1;
        ctl_d.tx_mode     = vhs_pkg::VHS_TX_NO_TONE;
        ctl_d.rx_mode     = vhs_pkg::VHS_RX_V22_LO;
        ctl_d.descram_en  = 1'b1;
        ctl_d.rx_usart_en = 1'b0;
      end
      ST_T3300: ctl_d.tx_mode = vhs_pkg::VHS_TX_ANS_TONE; // [RULE9]
      ST_T75:   ctl_d.tx_mode = vhs_pkg::VHS_TX_NO_TONE;  // [RULE10]
      ST_UNSCR: ctl_d.tx_mode = vhs_pkg::VHS_TX_HI_UNSCR1; // [RULE11]
      default: begin
      end
    endcase
    if (state_q == ST_PRE765 && state_d == ST_IDLE && !abort_i) begin
      ctl_d.tx_mode = vhs_pkg::VHS_TX_DATA;               // [RULE7] [RULE13]
      ctl_d.tx_sync = tx_sync_sel_i;
    end
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ctl_o <= vhs_pkg::CTL_RESET;
    end else begin
      ctl_o <= ctl_d;
    end
  end

  // ==========================================================
  // Dialling, preload and status
  // ==========================================================
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      dial_en_o <= 1'b0;
      tx_load_o <= 1'b0;
      tx_data_o <= 8'h00;
      busy_o    <= 1'b0;
    end else begin
      dial_en_o <= (state_d == ST_DIAL);                  // [RULE2]
      tx_load_o <= (state_d == ST_PRE765 && state_q != ST_PRE765);
      if (state_d == ST_PRE765 && state_q != ST_PRE765) begin
        tx_data_o <= first_byte_i;                        // [RULE6] [RULE12]
      end
      busy_o <= (state_d != ST_IDLE);
    end
  end

  // Connected holds until the next call or answer attempt starts
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      connected_o <= 1'b0;
      fail_o      <= 1'b0;
    end else if (state_q == ST_IDLE && state_d != ST_IDLE) begin
      connected_o <= 1'b0;
      fail_o      <= 1'b0;
    end else if (state_q == ST_PRE765 && expired && !abort_i) begin
      connected_o <= 1'b1;                                // [RULE13]
    end else if (state_q == ST_G456 && expired && !det_i.ans_2225 &&
                 !abort_i) begin
      fail_o <= 1'b1;                                     // [RULE14]
    end
  end

endmodule

/* design/vhs_pkg.sv */
package vhs_pkg;

  // ==========================================================
  // Timing
  // ==========================================================
  localparam int unsigned CLK_HZ       = 250_000_000;
  localparam int unsigned MS_CYCLES    = CLK_HZ / 1000;
  localparam int unsigned T_ANS_HI_MS  = 155;
  localparam int unsigned T_GUARD_MS   = 456;
  localparam int unsigned T_SCR_MS     = 270;
  localparam int unsigned T_PRELOAD_MS = 765;
  localparam int unsigned T_RING_MS    = 2150;
  localparam int unsigned T_TONE_MS    = 3300;
  localparam int unsigned T_SIL_MS     = 75;

  // ==========================================================
  // Transmit and receive mode codes presented to the modem
  // ==========================================================
  typedef enum logic [2:0] {
    VHS_TX_NO_TONE   = 3'h0,
    VHS_TX_DTMF      = 3'h1,
    VHS_TX_ANS_TONE  = 3'h2,
    VHS_TX_LO_SCR1   = 3'h3,
    VHS_TX_HI_UNSCR1 = 3'h4,
    VHS_TX_HI_SCR1   = 3'h5,
    VHS_TX_DATA      = 3'h6
  } vhs_tx_mode_t;

  typedef enum logic [1:0] {
    VHS_RX_CALL_PROG = 2'h0,
    VHS_RX_ANS_DET   = 2'h1,
    VHS_RX_V22_HI    = 2'h2,
    VHS_RX_V22_LO    = 2'h3
  } vhs_rx_mode_t;

  // Everything the modem is told except the byte load and its data, in one bundle
  typedef struct packed {
    logic         power_up;
    logic         off_hook;
    vhs_tx_mode_t tx_mode;
    vhs_rx_mode_t rx_mode;
    logic         descram_en;
    logic         rx_usart_en;
    logic         tx_sync;
  } vhs_modem_ctl_t;

  // Detector reports from the modem
  typedef struct packed {
    logic ring;
    logic ans_2100;
    logic ans_2225;
    logic scr_ones;
  } vhs_det_t;

  localparam vhs_modem_ctl_t CTL_RESET = '{
    power_up: 1'b0, off_hook: 1'b0, tx_mode: VHS_TX_NO_TONE,
    rx_mode: VHS_RX_CALL_PROG, descram_en: 1'b0, rx_usart_en: 1'b0,
    tx_sync: 1'b0};

endpackage

/* verification/vhs_sequencer_chk.sv */
module vhs_sequencer_chk (
  input wire logic                    clk_sys_i,
  input wire logic                    resetn_i,
  input wire vhs_pkg::vhs_det_t       det_i,
  input wire vhs_pkg::vhs_modem_ctl_t ctl_o,
  input wire logic                    dial_en_o,
  input wire logic                    tx_load_o,
  input wire logic                    connected_o,
  input wire logic                    fail_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);

  // ==========================================================
  // Mode bundles
  // ==========================================================
  property p_dial;
    dial_en_o |-> ctl_o.off_hook && ctl_o.power_up &&
      ctl_o.tx_mode == vhs_pkg::VHS_TX_DTMF &&
      ctl_o.rx_mode == vhs_pkg::VHS_RX_CALL_PROG;
  endproperty
  a_dial: assert property (p_dial)
    else $error("dialling without line set up");
  property p_lo;
    ctl_o.tx_mode == vhs_pkg::VHS_TX_LO_SCR1 |->
      ctl_o.rx_mode == vhs_pkg::VHS_RX_V22_HI && ctl_o.descram_en;
  endproperty
  a_lo: assert property (p_lo)
    else $error("low band tx without high band rx");
  property p_ans_rx;
    ctl_o.tx_mode == vhs_pkg::VHS_TX_ANS_TONE |-> ctl_o.off_hook &&
      ctl_o.rx_mode == vhs_pkg::VHS_RX_V22_LO && ctl_o.descram_en &&
      !ctl_o.rx_usart_en;
  endproperty
  a_ans_rx: assert property (p_ans_rx)
    else $error("answer tone with wrong receive set up");

  // ==========================================================
  // Phase order
  // ==========================================================
  property p_unscr;
    $rose(ctl_o.tx_mode == vhs_pkg::VHS_TX_HI_UNSCR1) |->
      $past(ctl_o.tx_mode) == vhs_pkg::VHS_TX_NO_TONE;
  endproperty
  a_unscr: assert property (p_unscr)
    else $error("unscrambled ones not after silence");
  property p_hiscr;
    $rose(ctl_o.tx_mode == vhs_pkg::VHS_TX_HI_SCR1) |->
      $past(ctl_o.tx_mode) == vhs_pkg::VHS_TX_HI_UNSCR1 &&
      $past(det_i.scr_ones);
  endproperty
  a_hiscr: assert property (p_hiscr)
    else $error("high band scrambled ones without cause");
  property p_load;
    tx_load_o |-> ##1 !tx_load_o && ctl_o.rx_usart_en;
  endproperty
  a_load: assert property (p_load)
    else $error("byte load not a pulse or usart off");
  property p_data;
    $rose(ctl_o.tx_mode == vhs_pkg::VHS_TX_DATA) |-> connected_o &&
      ctl_o.rx_usart_en && $past(ctl_o.tx_mode) inside
      {vhs_pkg::VHS_TX_LO_SCR1, vhs_pkg::VHS_TX_HI_SCR1};
  endproperty
  a_data: assert property (p_data)
    else $error("data mode entered out of order");
  property p_fail;
    $rose(fail_o) |-> !ctl_o.off_hook &&
      ctl_o.tx_mode == vhs_pkg::VHS_TX_NO_TONE;
  endproperty
  a_fail: assert property (p_fail)
    else $error("failure left line held or tone on");
endmodule

bind vhs_sequencer vhs_sequencer_chk i_vhs_sequencer_chk (
  .clk_sys_i, .resetn_i, .det_i, .ctl_o, .dial_en_o, .tx_load_o,
  .connected_o, .fail_o);

/* verification/vhs_modem_model.sv */
module vhs_modem_model (
  input  wire logic                    clk_sys_i,
  input  wire vhs_pkg::vhs_modem_ctl_t ctl_i,
  input  wire logic                    tx_load_i,
  input  wire logic [7:0]              tx_data_i,
  input  wire logic [4:0]              line_i,
  output vhs_pkg::vhs_det_t            det_o,
  output logic [7:0]                   sent_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Line bits: ring, 2100 tone, 2225 tone, unscrambled ones, scrambled
  logic [7:0] buf_q = 8'h00;
  logic       ans_det;
  assign ans_det = ctl_i.power_up && ctl_i.rx_mode == vhs_pkg::VHS_RX_ANS_DET;
  // Ring detector keeps running in powersave
  assign det_o.ring = line_i[4];
  assign det_o.ans_2100 = ans_det && line_i[3];
  assign det_o.ans_2225 = ans_det && (line_i[2] || line_i[1]);
  assign det_o.scr_ones = ctl_i.power_up && ctl_i.descram_en && line_i[0];
  always @(posedge clk_sys_i) if (tx_load_i) buf_q <= tx_data_i;
  // Idle line shows the inverse so a stale byte never matches
  assign sent_o = (ctl_i.tx_mode == vhs_pkg::VHS_TX_DATA) ?
    buf_q : ~buf_q;
endmodule

/* verification/vhs_sequencer_tb.sv */
module vhs_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int M = 2;
  logic                    clk_sys_i = 1'b0;
  logic                    resetn_i = 1'b0;
  logic                    call_start_i = 1'b0;
  logic                    answer_en_i = 1'b0;
  logic                    abort_i = 1'b0;
  logic                    dial_done_i = 1'b0;
  logic                    tx_sync_sel_i = 1'b0;
  logic [7:0]              first_byte_i = 8'h00;
  logic [4:0]              line = 5'h00;
  vhs_pkg::vhs_det_t       det_i;
  vhs_pkg::vhs_modem_ctl_t ctl_o;
  logic                    dial_en_o, tx_load_o, connected_o, fail_o, busy_o;
  logic [7:0]              tx_data_o, sent;
  logic [31:0]             seed = 32'h97ba_21d9;
  logic [31:0]             prev = 32'h0000_0000;
  int                      error_cnt = 0, n_tests = 0, n;
  int                      exp_q[$];

  vhs_sequencer #(.MS_CYC(M)) i_vhs_sequencer (.clk_sys_i, .resetn_i,
    .call_start_i, .answer_en_i, .abort_i, .dial_done_i, .tx_sync_sel_i,
    .first_byte_i, .det_i, .ctl_o, .dial_en_o, .tx_load_o, .tx_data_o,
    .connected_o, .fail_o, .busy_o);
  vhs_modem_model i_vhs_modem_model (.clk_sys_i, .ctl_i(ctl_o),
    .tx_load_i(tx_load_o), .tx_data_i(tx_data_o), .line_i(line),
    .det_o(det_i), .sent_o(sent));

  initial forever #2 clk_sys_i = ~clk_sys_i;

  // Dialling and no tone both leave the line quiet, so one class
  function automatic logic [31:0] cls(logic [2:0] m);
    return (m <= 3'h1) ? 32'h0000_0000 : {29'h0000_0000, m};
  endfunction
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    n_tests++;
    if (e !== g) begin
      error_cnt++;
      $display("mismatch %s exp %0h got %0h", nm, e, g);
    end
  endtask
  task automatic wait_cls(logic [31:0] c, int e, string nm);
    n = 0;
    do begin
      @(posedge clk_sys_i);
      #1 n++;
    end while (cls(ctl_o.tx_mode) !== c && n < 20000);
    chk(nm, c, cls(ctl_o.tx_mode));
    if (n < e || n > e + 8) chk(nm, e, n);
  endtask
  task automatic rnd_inputs;
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    @(posedge clk_sys_i) first_byte_i <= seed[7:0];
    tx_sync_sel_i <= seed[8];
  endtask
  task automatic do_abort;
    @(posedge clk_sys_i) abort_i <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    #1 chk("abort", 2'b00, {busy_o, ctl_o.off_hook});
    @(posedge clk_sys_i) abort_i <= 1'b0;
  endtask
  task automatic call_up;
    @(posedge clk_sys_i) call_start_i <= 1'b1;
    @(posedge clk_sys_i) call_start_i <= 1'b0;
    #1 chk("dial", 3'b111,
      {dial_en_o, ctl_o.power_up, ctl_o.off_hook});
    @(posedge clk_sys_i) dial_done_i <= 1'b1;
    @(posedge clk_sys_i) dial_done_i <= 1'b0;
    @(posedge clk_sys_i) line <= 5'h08;
    #1 chk("rx", vhs_pkg::VHS_RX_ANS_DET, ctl_o.rx_mode);
    repeat (20) @(posedge clk_sys_i);
  endtask
  task automatic connected;
    chk("byte", first_byte_i, sent);
    chk("sync", tx_sync_sel_i, ctl_o.tx_sync);
    chk("done", 2'b10, {connected_o, busy_o});
    do_abort;
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Every change of line class must be the next one the handshake allows
  always begin
    @(posedge clk_sys_i);
    #1;
    if (resetn_i && cls(ctl_o.tx_mode) !== prev) begin
      prev = cls(ctl_o.tx_mode);
      chk("mode", (exp_q.size() > 0) ? exp_q.pop_front() : 99, prev);
    end
  end
  // Whole run is near 22000 cycles
  initial begin
    repeat (40000) @(posedge clk_sys_i);
    error_cnt++;
    tally_and_finish;
  end

  initial begin
    repeat (10) @(posedge clk_sys_i);
    resetn_i <= 1'b1;
    rnd_inputs;
    exp_q = '{3, 6, 0};
    call_up;
    line <= 5'h02;
    wait_cls(3, 611 * M, "guard");
    @(posedge clk_sys_i) line <= 5'h01;
    wait_cls(6, 1035 * M, "link");
    connected;
    call_up;
    line <= 5'h04;
    repeat (300 * M) @(posedge clk_sys_i);
    line <= 5'h00;
    repeat (311 * M - 10) @(posedge clk_sys_i);
    #1 chk("early fail", 1'b0, fail_o);
    repeat (20) @(posedge clk_sys_i);
    #1 chk("fail", 2'b10, {fail_o, ctl_o.off_hook});
    do_abort;
    rnd_inputs;
    exp_q = '{2, 0, 4, 5, 6, 0, 2, 0};
    answer_en_i <= 1'b1;
    @(posedge clk_sys_i) line <= 5'h10;
    @(posedge clk_sys_i) line <= 5'h00;
    wait_cls(2, 2150 * M, "ring");
    wait_cls(0, 3300 * M, "tone");
    wait_cls(4, 75 * M, "silence");
    @(posedge clk_sys_i) line <= 5'h01;
    wait_cls(5, 270 * M, "scrambled");
    wait_cls(6, 765 * M, "preload");
    connected;
    // Answerer stays armed, so a call request must be refused
    @(posedge clk_sys_i) call_start_i <= 1'b1;
    @(posedge clk_sys_i) call_start_i <= 1'b0;
    #1 chk("refused", 1'b0, dial_en_o);
    @(posedge clk_sys_i) line <= 5'h10;
    @(posedge clk_sys_i) line <= 5'h00;
    wait_cls(2, 2150 * M, "ring again");
    do_abort;
    answer_en_i <= 1'b0;
    repeat (4) @(posedge clk_sys_i);
    chk("modes left", 0, exp_q.size());
    tally_and_finish;
  end
endmodule
